// ===== verilog/psb_defs.svh
// Constants for the power-on strap boot selector: strap codes, times, counts.
// Assumes a single 125 MHz reference clock; included by bare name.
`ifndef PSB_DEFS_SVH
`define PSB_DEFS_SVH

// Clock period in ns
`define PSB_CLK_NS 8

// Strap codes, bit 2 is the most significant strap
`define PSB_SERIAL_DOWNLOAD_CODE 3'h4
`define PSB_TWO_PIN_DEBUG_CODE 3'h1
`define PSB_FOUR_PIN_DEBUG_CODE 3'h0
`define PSB_BREAK_QUALIFIED_CODE 3'h2
`define PSB_FACTORY_RESTORE_CODE 3'h3

// Strap bit positions
`define PSB_STRAP_TOP 2
`define PSB_RF_LO 0
`define PSB_RF_HI 1

// Bit of the synchronised bundle that carries the serial receive line
`define PSB_RX_BIT 3

// Settling time of the strap pins after reset release, least time
`define PSB_SETTLE_NS 1000
`define PSB_SETTLE_CYC ((`PSB_SETTLE_NS + `PSB_CLK_NS - 1) / `PSB_CLK_NS)

// Least low time of the receive line that counts as a break
`define PSB_BREAK_LOW_NS 100000
`define PSB_BREAK_LOW_CYC ((`PSB_BREAK_LOW_NS + `PSB_CLK_NS - 1) / `PSB_CLK_NS)

// Longest time spent looking for a break
`define PSB_BREAK_WIN_NS 10000000
`define PSB_BREAK_WIN_CYC (`PSB_BREAK_WIN_NS / `PSB_CLK_NS)

// Reset values; the receive line bit resets to its idle high level,
// so the low-run counter never starts from a false low after reset
`define PSB_SYNC_RST 4'h8
`define PSB_CNT_RST 24'h000000

`endif

// ===== verilog/psb_pkg.sv
// Types for the power-on strap boot selector.
// Assumes psb_defs.svh is on the include path.
`default_nettype none
`include "psb_defs.svh"

package psb_pkg;

	typedef enum logic [2:0] {
		serial_download_boot,
		run_with_two_pin_debug,
		run_with_four_pin_debug,
		break_qualified_boot,
		factory_restore_boot
	} psb_flow_t;

	typedef enum logic [2:0] {
		ST_SETTLE,
		ST_LATCH,
		ST_BREAK,
		ST_APPLY,
		ST_RUN
	} psb_state_t;

	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
	} psb_sync_t;

	typedef struct packed {
		psb_state_t st;
		logic [23:0] cnt;
		logic [23:0] low_cnt;
		logic [2:0] code;
		psb_flow_t flow;
		logic brk_seen;
		logic core_rst;
		logic done;
		logic jtag4;
		logic swd2;
		logic uart_map;
		logic dl_wait;
		logic restore;
		logic [2:0] pin_out;
		logic [2:0] pin_oe;
	} psb_top_state_t;

	// Strap code to boot flow; unlisted codes fall back to four-pin run
	function automatic psb_flow_t decode_code(input logic [2:0] code);
		psb_flow_t f;
		f = run_with_four_pin_debug;
		case (code)
			`PSB_SERIAL_DOWNLOAD_CODE: f = serial_download_boot;
			`PSB_TWO_PIN_DEBUG_CODE: f = run_with_two_pin_debug;
			`PSB_FOUR_PIN_DEBUG_CODE: f = run_with_four_pin_debug;
			`PSB_BREAK_QUALIFIED_CODE: f = break_qualified_boot;
			`PSB_FACTORY_RESTORE_CODE: f = factory_restore_boot;
			default: f = run_with_four_pin_debug;
		endcase
		return f;
	endfunction

endpackage

`default_nettype wire

// ===== verilog/psb_sync.sv
// Two-flop synchroniser for the strap pins and the serial receive line.
// Assumes inputs are asynchronous pins; output is on ref_clk.
`default_nettype none
`include "psb_defs.svh"

module psb_sync (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [3:0] async_in,
	output logic [3:0] sync_out
);

	psb_pkg::psb_sync_t s_q;
	psb_pkg::psb_sync_t s_d;

	// First stage feeds only the second stage
	always_comb begin
		s_d = s_q;
		s_d.s1 = async_in;
		s_d.s2 = s_q.s1;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q <= {`PSB_SYNC_RST, `PSB_SYNC_RST};
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_out = s_q.s2;

endmodule

`default_nettype wire

// ===== verilog/psb_boot_select.sv
// Power-on strap boot selector: samples three straps, latches them, picks
// the boot flow, the debug and serial pin mapping, then hands the low two
// strap pins to the radio switch and the top pin to the application.
// Assumes rst is the power-up reset and holds the core (core_rst_q) until
// the boot flow is decided; external pulls set strap levels.
//
// Boot timeline, edges counted from the first edge with rst low
// Edges 1 to 125: settle counter, pulls and sync flops come to rest
// Edge 126: single strap capture and first decode
// Edge 127, flows other than break: mapping applied, core reset dropped, pins handed over
// Break flow: receive line watched from edge 127 until break or window end
// Download flow: dl_wait_q stays high until the next power-up reset
//
// Ports
// ref_clk: single reference clock, every flop runs on it
// rst: power-up reset, synchronous, active high
// strap_pin_in: live strap pin levels, bit 2 the top strap, asynchronous
// strap_pin_out_q: strap pin drive values, low two from the radio after boot
// strap_pin_oe_q: strap pin output enables, all low until boot is done
// uart_rx_pin: serial receive pin, asynchronous, idles high
// rf_sw_ctl: band switch control from the radio, same clock
// app_strap2_out: application drive value for the top strap pin
// app_strap2_oe: application output enable for the top strap pin
// strap_code_q: latched strap code, held until the next power-up
// boot_flow_q: resolved boot flow, meaningful once boot_done_q is high
// break_seen_q: break found on the receive line in break-qualified flow
// boot_done_q: boot decision complete, high until the next power-up
// core_rst_q: core reset, held high until the decision is complete
// dbg_jtag4_q: four-wire JTAG debug port enabled
// dbg_swd2_q: two-pin serial wire debug enabled
// uart_map_q: first serial port pins mapped
// dl_wait_q: waiting for a serial download, never times out
// restore_start_q: one-cycle start pulse of factory image restore
//
// Pin handover
// Strap pins are inputs only until boot is done
// Low two then drive the band switch and nothing else
// Top pin then belongs to the application, either direction
//
// Reset state
// Core reset high, four-pin flow assumed, every other output low
// Receive line sync resets to its idle high level
//
// Limits
// Straps must stay stable from reset release to the capture edge
// Top strap pin direction after boot is the application's choice
// Break and window lengths are parameters; the settle time is fixed
`default_nettype none
`include "psb_defs.svh"

module psb_boot_select #(
	parameter int unsigned BREAK_LOW_CYC = `PSB_BREAK_LOW_CYC,
	parameter int unsigned BREAK_WIN_CYC = `PSB_BREAK_WIN_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [2:0] strap_pin_in,
	output logic [2:0] strap_pin_out_q,
	output logic [2:0] strap_pin_oe_q,
	input wire logic uart_rx_pin,
	input wire logic [1:0] rf_sw_ctl,
	input wire logic app_strap2_out,
	input wire logic app_strap2_oe,
	output logic [2:0] strap_code_q,
	output psb_pkg::psb_flow_t boot_flow_q,
	output logic break_seen_q,
	output logic boot_done_q,
	output logic core_rst_q,
	output logic dbg_jtag4_q,
	output logic dbg_swd2_q,
	output logic uart_map_q,
	output logic dl_wait_q,
	output logic restore_start_q
);

	localparam logic [23:0] SETTLE_LAST = 24'(`PSB_SETTLE_CYC - 1);
	localparam logic [23:0] LOW_LAST = 24'(BREAK_LOW_CYC - 1);
	localparam logic [23:0] WIN_LAST = 24'(BREAK_WIN_CYC - 1);

	logic [3:0] pin_sync;
	logic rx_level;
	logic [2:0] strap_level;

	psb_pkg::psb_top_state_t s_q;
	psb_pkg::psb_top_state_t s_d;

	// Straps and receive line are pins, so both pass two flops
	psb_sync u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.async_in({uart_rx_pin, strap_pin_in}),
		.sync_out(pin_sync)
	);

	assign rx_level = pin_sync[`PSB_RX_BIT];
	assign strap_level = pin_sync[2:0];

	// Four-wire JTAG in download and four-pin runs; restore leaves debug off
	function automatic logic flow_jtag4(input psb_pkg::psb_flow_t f);
		logic on;
		on = 1'b0;
		case (f)
			psb_pkg::serial_download_boot: on = 1'b1;
			psb_pkg::run_with_two_pin_debug: on = 1'b0;
			psb_pkg::run_with_four_pin_debug: on = 1'b1;
			psb_pkg::break_qualified_boot: on = 1'b0;
			psb_pkg::factory_restore_boot: on = 1'b0;
			default: on = 1'b0;
		endcase
		return on;
	endfunction

	// Two-pin debug only in its own run flow
	function automatic logic flow_swd2(input psb_pkg::psb_flow_t f);
		logic on;
		on = 1'b0;
		case (f)
			psb_pkg::serial_download_boot: on = 1'b0;
			psb_pkg::run_with_two_pin_debug: on = 1'b1;
			psb_pkg::run_with_four_pin_debug: on = 1'b0;
			psb_pkg::break_qualified_boot: on = 1'b0;
			psb_pkg::factory_restore_boot: on = 1'b0;
			default: on = 1'b0;
		endcase
		return on;
	endfunction

	// After boot, first serial port stays mapped only while a download is awaited
	function automatic logic flow_uart_map(input psb_pkg::psb_flow_t f);
		logic on;
		on = 1'b0;
		case (f)
			psb_pkg::serial_download_boot: on = 1'b1;
			psb_pkg::run_with_two_pin_debug: on = 1'b0;
			psb_pkg::run_with_four_pin_debug: on = 1'b0;
			psb_pkg::break_qualified_boot: on = 1'b0;
			psb_pkg::factory_restore_boot: on = 1'b0;
			default: on = 1'b0;
		endcase
		return on;
	endfunction

	// Download wait has no timeout, so only a new power-up ends it
	function automatic logic flow_dl_wait(input psb_pkg::psb_flow_t f);
		logic on;
		on = 1'b0;
		case (f)
			psb_pkg::serial_download_boot: on = 1'b1;
			psb_pkg::run_with_two_pin_debug: on = 1'b0;
			psb_pkg::run_with_four_pin_debug: on = 1'b0;
			psb_pkg::break_qualified_boot: on = 1'b0;
			psb_pkg::factory_restore_boot: on = 1'b0;
			default: on = 1'b0;
		endcase
		return on;
	endfunction

	// Restore start; a pulse, since the restore engine runs on its own
	function automatic logic flow_restore(input psb_pkg::psb_flow_t f);
		logic on;
		on = 1'b0;
		case (f)
			psb_pkg::serial_download_boot: on = 1'b0;
			psb_pkg::run_with_two_pin_debug: on = 1'b0;
			psb_pkg::run_with_four_pin_debug: on = 1'b0;
			psb_pkg::break_qualified_boot: on = 1'b0;
			psb_pkg::factory_restore_boot: on = 1'b1;
			default: on = 1'b0;
		endcase
		return on;
	endfunction

	// Next-state logic of the boot sequence
	always_comb begin
		s_d = s_q;
		s_d.restore = 1'b0;
		case (s_q.st)
			// Sync flops and pulls need time before the sample counts
			psb_pkg::ST_SETTLE: begin
				if (s_q.cnt == SETTLE_LAST) begin
					s_d.cnt = `PSB_CNT_RST;
					s_d.st = psb_pkg::ST_LATCH;
				end else begin
					s_d.cnt = s_q.cnt + 24'h000001;
				end
			end
			// Single capture; nothing else ever writes code
			psb_pkg::ST_LATCH: begin
				s_d.code = strap_level;
				s_d.flow = psb_pkg::decode_code(strap_level);
				s_d.cnt = `PSB_CNT_RST;
				s_d.low_cnt = `PSB_CNT_RST;
				if (psb_pkg::decode_code(strap_level) == psb_pkg::break_qualified_boot) begin
					s_d.uart_map = 1'b1;
					s_d.st = psb_pkg::ST_BREAK;
				end else begin
					s_d.st = psb_pkg::ST_APPLY;
				end
			end
			// Break is a low run of the receive line inside the window
			psb_pkg::ST_BREAK: begin
				s_d.cnt = s_q.cnt + 24'h000001;
				if (rx_level) begin
					s_d.low_cnt = `PSB_CNT_RST;
				end else begin
					s_d.low_cnt = s_q.low_cnt + 24'h000001;
				end
				if (!rx_level && (s_q.low_cnt == LOW_LAST)) begin
					s_d.brk_seen = 1'b1;
					s_d.flow = psb_pkg::serial_download_boot;
					s_d.st = psb_pkg::ST_APPLY;
				end else if (s_q.cnt == WIN_LAST) begin
					s_d.flow = psb_pkg::run_with_four_pin_debug;
					s_d.st = psb_pkg::ST_APPLY;
				end
			end
			// Pin mapping follows the resolved flow; core leaves reset on the same edge
			psb_pkg::ST_APPLY: begin
				s_d.jtag4 = flow_jtag4(s_q.flow);
				s_d.swd2 = flow_swd2(s_q.flow);
				s_d.uart_map = flow_uart_map(s_q.flow);
				s_d.dl_wait = flow_dl_wait(s_q.flow);
				s_d.restore = flow_restore(s_q.flow);
				s_d.core_rst = 1'b0;
				s_d.done = 1'b1;
				s_d.st = psb_pkg::ST_RUN;
			end
			// Terminal: no timeout leaves download wait, no pin reloads code
			psb_pkg::ST_RUN: begin
				s_d.st = psb_pkg::ST_RUN;
			end
			default: begin
				s_d.st = psb_pkg::ST_SETTLE;
			end
		endcase
		// Strap pins stay inputs until boot is done, else the sample is spoiled
		if (s_d.done) begin
			s_d.pin_out[`PSB_RF_HI:`PSB_RF_LO] = rf_sw_ctl;
			s_d.pin_oe[`PSB_RF_HI:`PSB_RF_LO] = 2'h3;
			s_d.pin_out[`PSB_STRAP_TOP] = app_strap2_out;
			s_d.pin_oe[`PSB_STRAP_TOP] = app_strap2_oe;
		end else begin
			s_d.pin_out = 3'h0;
			s_d.pin_oe = 3'h0;
		end
	end

	// Power-up reset returns everything to the sampling start
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q.st <= psb_pkg::ST_SETTLE;
			s_q.cnt <= `PSB_CNT_RST;
			s_q.low_cnt <= `PSB_CNT_RST;
			s_q.code <= 3'h0;
			s_q.flow <= psb_pkg::run_with_four_pin_debug;
			s_q.brk_seen <= 1'b0;
			s_q.core_rst <= 1'b1;
			s_q.done <= 1'b0;
			s_q.jtag4 <= 1'b0;
			s_q.swd2 <= 1'b0;
			s_q.uart_map <= 1'b0;
			s_q.dl_wait <= 1'b0;
			s_q.restore <= 1'b0;
			s_q.pin_out <= 3'h0;
			s_q.pin_oe <= 3'h0;
		end else begin
			s_q <= s_d;
		end
	end

	// All outputs straight from the state register
	assign strap_pin_out_q = s_q.pin_out;
	assign strap_pin_oe_q = s_q.pin_oe;
	assign strap_code_q = s_q.code;
	assign boot_flow_q = s_q.flow;
	assign break_seen_q = s_q.brk_seen;
	assign boot_done_q = s_q.done;
	assign core_rst_q = s_q.core_rst;
	assign dbg_jtag4_q = s_q.jtag4;
	assign dbg_swd2_q = s_q.swd2;
	assign uart_map_q = s_q.uart_map;
	assign dl_wait_q = s_q.dl_wait;
	assign restore_start_q = s_q.restore;

endmodule

`default_nettype wire

// ===== sim/psb_asserts.sv
// Checker for the strap boot selector; watches only the top module's ports.
// Assumes one clock domain with a synchronous active-high reset.
`default_nettype none
module psb_asserts (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [2:0] strap_pin_out_q,
	input wire logic [2:0] strap_pin_oe_q,
	input wire logic [1:0] rf_sw_ctl,
	input wire logic app_strap2_oe,
	input wire logic [2:0] strap_code_q,
	input wire psb_pkg::psb_flow_t boot_flow_q,
	input wire logic break_seen_q,
	input wire logic boot_done_q,
	input wire logic core_rst_q,
	input wire logic dbg_jtag4_q,
	input wire logic dbg_swd2_q,
	input wire logic uart_map_q,
	input wire logic dl_wait_q,
	input wire logic restore_start_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Core held in reset until done; done, flow and the latched code freeze once done
	a_core_held: assert property (!boot_done_q |-> core_rst_q) else $error("core released early");
	a_code_frozen: assert property (boot_done_q |=> boot_done_q && $stable(strap_code_q) && $stable(boot_flow_q))
		else $error("boot result changed");
	// Pins stay undriven until boot, then the low two follow the radio and the top pin enable follows the application
	a_no_drive: assert property (!boot_done_q |-> strap_pin_oe_q == 3'h0) else $error("pins driven early");
	a_rf_follow: assert property (boot_done_q |=> strap_pin_oe_q[1:0] == 2'h3
		&& strap_pin_out_q[1:0] == $past(rf_sw_ctl)) else $error("band switch pins wrong");
	a_top_app: assert property (boot_done_q |=> strap_pin_oe_q[2] == $past(app_strap2_oe))
		else $error("top pin enable wrong");
	// Flow specific debug and serial mapping
	a_dl_flags: assert property (boot_done_q && boot_flow_q == psb_pkg::serial_download_boot
		|-> dbg_jtag4_q && uart_map_q && dl_wait_q) else $error("download mapping wrong");
	a_swd_only: assert property (boot_done_q |-> dbg_swd2_q == (boot_flow_q == psb_pkg::run_with_two_pin_debug))
		else $error("two pin debug wrong");
	a_jtag_run: assert property (boot_done_q && boot_flow_q == psb_pkg::run_with_four_pin_debug
		|-> dbg_jtag4_q && !dl_wait_q) else $error("four pin debug wrong");
	a_break_dl: assert property (break_seen_q |-> boot_flow_q == psb_pkg::serial_download_boot)
		else $error("break without download");
	a_restore_pulse: assert property (restore_start_q |-> boot_flow_q == psb_pkg::factory_restore_boot
		##1 !restore_start_q) else $error("restore pulse wrong");
endmodule
bind psb_boot_select psb_asserts psb_asserts_inst (
	.ref_clk(ref_clk),
	.rst(rst),
	.strap_pin_out_q(strap_pin_out_q),
	.strap_pin_oe_q(strap_pin_oe_q),
	.rf_sw_ctl(rf_sw_ctl),
	.app_strap2_oe(app_strap2_oe),
	.strap_code_q(strap_code_q),
	.boot_flow_q(boot_flow_q),
	.break_seen_q(break_seen_q),
	.boot_done_q(boot_done_q),
	.core_rst_q(core_rst_q),
	.dbg_jtag4_q(dbg_jtag4_q),
	.dbg_swd2_q(dbg_swd2_q),
	.uart_map_q(uart_map_q),
	.dl_wait_q(dl_wait_q),
	.restore_start_q(restore_start_q)
);
`default_nettype wire

// ===== sim/psb_far_side.sv
// Far-side model: strap pull resistors and the serial loader host.
// Assumes the bench sets the pull levels and the break request.
`default_nettype none
module psb_far_side (
	input wire logic [2:0] pull,
	input wire logic brk,
	input wire logic [2:0] pin_out,
	input wire logic [2:0] pin_oe,
	output logic [2:0] pin,
	output logic rx
);
	timeunit 1ns;
	timeprecision 1ps;
	// Driven pin wins over its pull; an undriven pin, top pin included, reads back its pull
	assign pin = (pin_oe & pin_out) | (~pin_oe & pull);
	// Host holds receive low for a break, else idle high by pull-up
	assign rx = ~brk;
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench: every strap code, both break cases, pin handover.
// Assumes small break counts; straps change only as reset is raised or after boot is done.
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; $display("[ERR] %0t mismatch", $time); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, rst = 1, brk = 0, a_out = 0, a_oe = 0, rx, bs, done, crst, j4, s2, um, dw, rs;
	logic [2:0] pull = 0, pin, p_out, p_oe, sc, code;
	logic [1:0] rf = 0;
	psb_pkg::psb_flow_t flow, e;
	int miscompares = 0, check_count = 0, n;
	psb_far_side psb_far_side_inst (.pull(pull), .brk(brk), .pin_out(p_out), .pin_oe(p_oe), .pin(pin), .rx(rx));
	psb_boot_select #(.BREAK_LOW_CYC(4), .BREAK_WIN_CYC(50)) psb_boot_select_inst (.ref_clk(ref_clk), .rst(rst),
		.strap_pin_in(pin), .strap_pin_out_q(p_out), .strap_pin_oe_q(p_oe), .uart_rx_pin(rx), .rf_sw_ctl(rf),
		.app_strap2_out(a_out), .app_strap2_oe(a_oe), .strap_code_q(sc), .boot_flow_q(flow), .break_seen_q(bs),
		.boot_done_q(done), .core_rst_q(crst), .dbg_jtag4_q(j4), .dbg_swd2_q(s2), .uart_map_q(um),
		.dl_wait_q(dw), .restore_start_q(rs));
	// Reference flow; unlisted codes run with four-pin debug
	function automatic psb_pkg::psb_flow_t ef(input logic [2:0] c, input logic b);
		case (c)
			3'h4: return psb_pkg::serial_download_boot;
			3'h1: return psb_pkg::run_with_two_pin_debug;
			3'h2: return b ? psb_pkg::serial_download_boot : psb_pkg::run_with_four_pin_debug;
			3'h3: return psb_pkg::factory_restore_boot;
			default: return psb_pkg::run_with_four_pin_debug;
		endcase
	endfunction
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// One power-up with new straps, counting edges to done
	task automatic boot(input logic [2:0] c, input logic b);
		@(posedge ref_clk);
		pull <= c;
		brk <= b;
		rst <= 1;
		repeat (4) @(posedge ref_clk);
		rst <= 0;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (done !== 1'b1 && n < 400);
		if (n >= 400) begin
			miscompares++;
			end_of_test();
		end
	endtask
	// Free-running 125 MHz clock
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	// Every code, plus the break case; then shake pins after boot
	initial begin
		void'($urandom(32'h9151));
		for (int i = 0; i < 9; i++) begin
			code = (i == 8) ? 3'h2 : 3'(i);
			e = ef(code, i == 8);
			boot(code, i == 8);
			`CHK(sc, code)
			`CHK(flow, e)
			`CHK(bs, 1'(i == 8))
			if (code != 3'h2) `CHK(n, 127)
			`CHK(j4, 1'(e == psb_pkg::serial_download_boot || e == psb_pkg::run_with_four_pin_debug))
			`CHK(s2, 1'(e == psb_pkg::run_with_two_pin_debug))
			`CHK(dw, 1'(e == psb_pkg::serial_download_boot))
			`CHK(um, 1'(e == psb_pkg::serial_download_boot))
			`CHK(rs, 1'(e == psb_pkg::factory_restore_boot))
			`CHK(crst, 1'b0)
			repeat (8) begin
				@(posedge ref_clk);
				pull <= 3'($urandom);
				rf <= 2'($urandom);
				a_out <= 1'($urandom);
				a_oe <= 1'($urandom);
				repeat (2) @(posedge ref_clk);
				#1;
				`CHK(p_out, {a_out, rf})
				`CHK(p_oe, {a_oe, 2'h3})
				`CHK(sc, code)
				`CHK(flow, e)
				`CHK(dw, 1'(e == psb_pkg::serial_download_boot))
			end
		end
		end_of_test();
	end
endmodule
`default_nettype wire
